// [common/igd_pkg.sv]
package igd_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int DEGLITCH_NS = 40;
   localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAULT_MUTE_NS = 1000;
   localparam int FAULT_MUTE_CYC = FAULT_MUTE_NS / CLK_PERIOD_NS;
   localparam int RESET_FILTER_NS = 1000;
   localparam int RESET_FILTER_CYC = (RESET_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SENSE_W = 8;
   localparam logic [SENSE_W-1:0] SENSE_PERIOD = 8'h63;
   localparam int CNT_W = 8;

   typedef enum logic [1:0] {
      IGD_OFF = 2'b00,
      IGD_ON = 2'b01,
      IGD_FAULT = 2'b10
   } igd_state_t;

   typedef struct packed {
      logic in_pos;
      logic in_neg;
      logic enable;
   } igd_inputs_t;
endpackage

// [verif/igd_ctrl_tb.sv]
`timescale 1ns/1ps
module igd_ctrl_tb;
   import igd_pkg::*;
   logic clk = 0, rst = 1, pos = 0, neg = 0, en = 0, single = 1, sense_in_a = 0;
   logic supply_in_ok = 1, supply_out_ok = 1;
   logic [SENSE_W-1:0] analog_sense_in = 8'hE1;
   igd_inputs_t pins_in;
   logic gate_source_out, gate_sink_out, gate_soft_out, miller_clamp_out, fault_flag_n_out;
   logic fault_flag_n_oe_n, ready_out, ready_oe_n, sense_pwm_out, fault_line, ready_line;
   int error_cnt = 0, n_compared = 0, hi;
   always #12.5 clk = ~clk;
   igd_ctrl i_igd_ctrl (.*);
   igd_host i_igd_host (.*);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // inputs move 2 ns after an edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic t_on;
      pos = 1; en = 1; cyc(8);
      chk(gate_source_out, 1'h1);
      chk(miller_clamp_out, 1'h0);
      en = 0; cyc(1); en = 1; cyc(6);
      chk(gate_source_out, 1'h1);
      pos = 0; cyc(8); pos = 1; cyc(1); pos = 0; cyc(6);
      chk(gate_source_out, 1'h0);
   endtask
   task automatic t_lock;
      single = 0; pos = 1; neg = 1; cyc(8);
      chk(gate_source_out, 1'h0);
      neg = 0; cyc(8);
      chk(gate_source_out, 1'h1);
   endtask
   task automatic t_uv;
      supply_out_ok = 0; cyc(8);
      chk({gate_source_out, ready_line, sense_pwm_out}, 8'h0);
      chk(gate_sink_out, 1'h1);
      supply_out_ok = 1; supply_in_ok = 0; cyc(8);
      chk(ready_line, 1'h0);
      supply_in_ok = 1; cyc(10);
      chk({ready_line, gate_source_out}, 8'h3);
   endtask
   // duty of ~E1 is 30 of 100 cycles
   task automatic t_pwm;
      hi = 0;
      repeat (200) begin
         cyc(1);
         if (sense_pwm_out === 1'h1) hi++;
      end
      chk(hi[7:0], 8'h3C);
   endtask
   task automatic t_fault;
      sense_in_a = 1; cyc(3);
      chk({fault_line, gate_source_out, gate_soft_out}, 8'h1);
      chk(gate_sink_out, 1'h0);
      sense_in_a = 0; en = 0; cyc(10); en = 1; cyc(8);
      chk(fault_line, 1'h0);
      en = 0; cyc(90);
      chk(sense_pwm_out, 1'h0);
      en = 1; cyc(8);
      chk({fault_line, gate_source_out}, 8'h3);
   endtask
   initial begin
      cyc(5);
      rst = 0;
      t_on; t_lock; t_uv; t_pwm; t_fault;
      complete_run;
   end
   // watchdog
   initial begin
      cyc(2000);
      error_cnt++;
      complete_run;
   end
endmodule

// [verif/igd_host.sv]
`timescale 1ns/1ps
// ---
// host model: pins and pulled-up flags
// ---
module igd_host
   import igd_pkg::*;
(
   input wire logic pos,
   input wire logic neg,
   input wire logic en,
   input wire logic single,
   input wire logic fault_flag_n_out,
   input wire logic fault_flag_n_oe_n,
   input wire logic ready_out,
   input wire logic ready_oe_n,
   output igd_inputs_t pins_in,
   output logic fault_line,
   output logic ready_line
);
   // pins always driven; unused inverting input grounded
   assign pins_in = '{pos, single ? 1'h0 : neg, en};
   // released lines read high through pull-ups
   assign fault_line = fault_flag_n_oe_n ? 1'h1 : fault_flag_n_out;
   assign ready_line = ready_oe_n ? 1'h1 : ready_out;
endmodule

// [verif/igd_props.sv]
`timescale 1ns/1ps
// ---
// gate drive checker
// ---
module igd_props
   import igd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire igd_inputs_t pins_in,
   input wire logic supply_in_ok,
   input wire logic supply_out_ok,
   input wire logic sense_in_a,
   input wire logic [SENSE_W-1:0] analog_sense_in,
   input wire logic gate_source_out,
   input wire logic gate_sink_out,
   input wire logic gate_soft_out,
   input wire logic miller_clamp_out,
   input wire logic fault_flag_n_out,
   input wire logic fault_flag_n_oe_n,
   input wire logic ready_out,
   input wire logic ready_oe_n,
   input wire logic sense_pwm_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // overlapping paths would short the gate supply
   drive_excl_a: assert property (!(gate_source_out && (gate_sink_out || gate_soft_out)))
      else $error("drive overlap");
   clamp_off_a: assert property (gate_source_out |-> !miller_clamp_out)
      else $error("clamp on");
   od_low_a: assert property (!fault_flag_n_out && !ready_out)
      else $error("flag driven high");
   latch_off_a: assert property (!fault_flag_n_oe_n |-> !gate_source_out)
      else $error("on in fault");
   sense_in_a_trip_a: assert property (sense_in_a && gate_source_out && supply_in_ok && supply_out_ok
      |-> ##[1:3] (!fault_flag_n_oe_n && gate_soft_out))
      else $error("no trip");
   uv_off_a: assert property (!supply_out_ok [*6] |-> !gate_source_out && !ready_oe_n
      && !sense_pwm_out)
      else $error("uv not off");
   en_off_a: assert property (!pins_in.enable [*7] |-> !gate_source_out && !sense_pwm_out)
      else $error("on while disabled");
   interlock_a: assert property ((pins_in.in_pos && pins_in.in_neg) [*7] |-> !gate_source_out)
      else $error("interlock");
   // main scenarios
   cover property (gate_source_out);
   cover property (!fault_flag_n_oe_n);
   cover property (!supply_out_ok && !ready_oe_n);
endmodule

bind igd_ctrl igd_props i_igd_props (.*);

// [verilog/igd_ctrl.sv]
`timescale 1ns/1ps
module igd_ctrl
   import igd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire igd_inputs_t pins_in,
   input wire logic supply_in_ok,
   input wire logic supply_out_ok,
   input wire logic sense_in_a,
   input wire logic [SENSE_W-1:0] analog_sense_in,
   output logic gate_source_out,
   output logic gate_sink_out,
   output logic gate_soft_out,
   output logic miller_clamp_out,
   output logic fault_flag_n_out,
   output logic fault_flag_n_oe_n,
   output logic ready_out,
   output logic ready_oe_n,
   output logic sense_pwm_out
);
   // ----------------------------------------
   // input deglitch
   // ----------------------------------------
   igd_inputs_t filt;
   igd_inputs_t prev;
   logic [CNT_W-1:0] dg_cnt [3];
   logic [CNT_W-1:0] low_cnt;
   logic [CNT_W-1:0] mute_cnt;
   logic [SENSE_W-1:0] pwm_cnt;
   logic en_low_ok;
   logic supplies_ok;
   igd_state_t state;

   // either supply in lockout counts as lost power; both sides must be good
   assign supplies_ok = supply_in_ok & supply_out_ok;

   // ----------------------------------------
   // timing notes
   // ----------------------------------------
   // a pin change is seen by the counter at the same edge it is sampled,
   // so a level must stand DEGLITCH_CYC + 2 edges before filt follows it;
   // a single-cycle glitch resets the counter twice and is never believed.
   // the drive state then takes one more edge and the registered outputs
   // one more, so the gate answers about six edges after a valid combo.
   // a desaturation trip is two edges from sense to the flag pin.

   // a level must hold DEGLITCH_CYC + 2 cycles before it is believed
   always_ff @(posedge clk) begin
      if (rst) begin
         filt <= '0; // enable reads low until proven high
         prev <= '0;
         for (int i = 0; i < 3; i++) begin
            dg_cnt[i] <= '0;
         end
      end else begin
         prev <= pins_in;
         for (int i = 0; i < 3; i++) begin
            if (pins_in[i] != prev[i]) begin
               dg_cnt[i] <= '0;
            end else if (dg_cnt[i] < CNT_W'(DEGLITCH_CYC)) begin
               dg_cnt[i] <= dg_cnt[i] + 8'h01;
            end else begin
               filt[i] <= prev[i];
            end
         end
      end
   end

   // ----------------------------------------
   // fault mute and reset filter
   // ----------------------------------------
   // enable low counts only once mute has expired, so early resets are lost
   always_ff @(posedge clk) begin
      if (rst) begin
         mute_cnt <= '0;
         low_cnt <= '0;
         en_low_ok <= 1'b0;
      end else begin
         if (state != IGD_FAULT) begin
            mute_cnt <= CNT_W'(FAULT_MUTE_CYC);
         end else if (mute_cnt != '0) begin
            mute_cnt <= mute_cnt - 8'h01;
         end
         if (filt.enable || mute_cnt != '0) begin
            low_cnt <= '0;
         end else if (low_cnt < CNT_W'(RESET_FILTER_CYC)) begin
            low_cnt <= low_cnt + 8'h01;
         end
         en_low_ok <= (low_cnt >= CNT_W'(RESET_FILTER_CYC));
      end
   end

   // ----------------------------------------
   // drive state
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= IGD_OFF;
      end else begin
         case (state)
            IGD_OFF, IGD_ON: begin
               if (state == IGD_ON && sense_in_a && supplies_ok) begin
                  state <= IGD_FAULT;
               end else if (supplies_ok && filt.enable && filt.in_pos && !filt.in_neg) begin
                  state <= IGD_ON;
               end else begin
                  state <= IGD_OFF;
               end
            end
            IGD_FAULT: begin
               // released only on enable rising after a valid low
               if (en_low_ok && filt.enable) begin
                  state <= IGD_OFF;
               end
            end
            default: state <= IGD_OFF;
         endcase
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // the pull-up path is on only in the on state with both supplies good;
   // the clamp uses the same term, so one function keeps them in step
   function automatic logic drive_on(input igd_state_t st, input logic ok);
      return (st == IGD_ON) && ok;
   endfunction

   // source path: pulls the gate up
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_source_out <= 1'b0;
      end else begin
         gate_source_out <= drive_on(state, supplies_ok);
      end
   end

   // strong sink: normal turn-off and undervoltage
   // lockout wins over a latched fault, since soft turn-off needs supply
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_sink_out <= 1'b1;
      end else begin
         gate_sink_out <= (state == IGD_OFF) || !supplies_ok;
      end
   end

   // soft sink: fault turn-off only, limits overshoot on a short
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_soft_out <= 1'b0;
      end else begin
         gate_soft_out <= (state == IGD_FAULT) && supplies_ok;
      end
   end

   // clamp holds the gate down whenever the source is not driving
   always_ff @(posedge clk) begin
      if (rst) begin
         miller_clamp_out <= 1'b1;
      end else begin
         miller_clamp_out <= !drive_on(state, supplies_ok);
      end
   end

   // open drain: output level fixed low, oe_n low pulls the pin
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_flag_n_out <= 1'b0;
         fault_flag_n_oe_n <= 1'b1;
         ready_out <= 1'b0;
         ready_oe_n <= 1'b0;
      end else begin
         fault_flag_n_out <= 1'b0;
         fault_flag_n_oe_n <= (state != IGD_FAULT);
         ready_out <= 1'b0;
         ready_oe_n <= supplies_ok;
      end
   end

   // ----------------------------------------
   // analog to pwm
   // ----------------------------------------
   // higher sense voltage gives a shorter duty, as for an ntc sensor
   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_cnt <= '0;
         sense_pwm_out <= 1'b0;
      end else begin
         pwm_cnt <= (pwm_cnt >= SENSE_PERIOD) ? '0 : pwm_cnt + 8'h01;
         if (!supplies_ok || !filt.enable) begin
            sense_pwm_out <= 1'b0;
         end else begin
            sense_pwm_out <= (pwm_cnt < ~analog_sense_in);
         end
      end
   end
endmodule
